// ### rtl/sdwl_loader.sv
// Serial word loader: shift register, converter latch and control decode
`timescale 1ns/1ps
module sdwl_loader #(
	parameter int AMPS = sdwl_pkg::AMP_COUNT
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Serial pins
	input wire logic i_select_n,
	input wire logic i_word_framing_strobe,
	input wire logic i_sclk,
	input wire logic i_sdata,
	// Converter controls
	output logic [11:0] o_code,
	output logic o_settling_speed_bit,
	output logic o_power_down_bit,
	output logic [AMPS-1:0] o_amp_disable,
	output logic o_update
);
	sdwl_pkg::sdwl_pins_t raw, pins, prev_reg, prev_next;
	sdwl_pkg::sdwl_state_t state_reg, state_next;
	sdwl_pkg::sdwl_latch_t latch_reg, latch_next;
	logic [15:0] shift_reg, shift_next;
	logic [4:0] count_reg, count_next;
	logic [AMPS-1:0] amp_reg, amp_next;
	logic upd_reg, upd_next;
	logic fs_fall, fs_rise, ck_fall, ck_rise, active;

	assign raw = '{select_n: i_select_n, frame: i_word_framing_strobe,
		sclk: i_sclk, data: i_sdata};

	sdwl_sync #(.WIDTH(4)) u_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_async(raw),
		.i_reset_level(sdwl_pkg::PINS_RESET),
		.o_level(pins)
	);

	// Load the shifted word into the latch; bits 15 and 12 dropped
	function automatic sdwl_pkg::sdwl_latch_t decode(input logic [15:0] w);
		sdwl_pkg::sdwl_latch_t l;
		l.settling_speed_bit = w[sdwl_pkg::SPEED_POS];
		l.power_down_bit = w[sdwl_pkg::POWER_POS];
		l.code = w[sdwl_pkg::CODE_MSB:0];
		return l;
	endfunction

	assign active = !pins.select_n;
	assign fs_fall = prev_reg.frame && !pins.frame;
	assign fs_rise = !prev_reg.frame && pins.frame;
	assign ck_fall = prev_reg.sclk && !pins.sclk;
	assign ck_rise = !prev_reg.sclk && pins.sclk;

	always_comb begin
		prev_next = pins;
		state_next = state_reg;
		shift_next = shift_reg;
		count_next = count_reg;
		latch_next = latch_reg;
		upd_next = 1'b0;
		if (!active) begin
			// Select high: shift, count and latch frozen, frame abandoned
			state_next = sdwl_pkg::ST_IDLE;
		end else begin
			unique case (state_reg)
			sdwl_pkg::ST_IDLE, sdwl_pkg::ST_DONE: begin
				if (fs_fall) begin
					state_next = sdwl_pkg::ST_SHIFT;
					count_next = sdwl_pkg::COUNT_RESET;
				end
			end
			sdwl_pkg::ST_SHIFT: begin
				if (fs_rise) begin
					// Early end of frame loads what has shifted
					latch_next = decode(shift_reg);
					upd_next = 1'b1;
					state_next = sdwl_pkg::ST_IDLE;
				end else if (ck_fall) begin
					shift_next = {shift_reg[14:0], pins.data};
					count_next = 5'(count_reg + 5'h01);
					if (5'(count_reg + 5'h01) == sdwl_pkg::COUNT_FULL) begin
						state_next = sdwl_pkg::ST_WAIT_RISE;
					end
				end
			end
			sdwl_pkg::ST_WAIT_RISE: begin
				if (ck_rise || fs_rise) begin
					latch_next = decode(shift_reg);
					upd_next = 1'b1;
					state_next = sdwl_pkg::ST_DONE;
				end
			end
			endcase
		end
		amp_next = {AMPS{latch_next.power_down_bit}};
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			prev_reg <= sdwl_pkg::PINS_RESET;
			state_reg <= sdwl_pkg::ST_IDLE;
			shift_reg <= sdwl_pkg::WORD_RESET;
			count_reg <= sdwl_pkg::COUNT_RESET;
			latch_reg <= sdwl_pkg::LATCH_RESET;
			amp_reg <= '0;
			upd_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			state_reg <= state_next;
			shift_reg <= shift_next;
			count_reg <= count_next;
			latch_reg <= latch_next;
			amp_reg <= amp_next;
			upd_reg <= upd_next;
		end
	end

	assign o_code = latch_reg.code;
	assign o_settling_speed_bit = latch_reg.settling_speed_bit;
	assign o_power_down_bit = latch_reg.power_down_bit;
	assign o_amp_disable = amp_reg;
	assign o_update = upd_reg;
endmodule

// ### rtl/sdwl_pkg.sv
// Package with constants and types for the serial word loader
package sdwl_pkg;
	localparam int WORD_BITS = 16;
	localparam int CODE_BITS = 12;
	localparam int SPEED_POS = 14;
	localparam int POWER_POS = 13;
	localparam int CODE_MSB = 11;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [13:0] LATCH_RESET = 14'h0000;
	localparam logic [3:0] PINS_RESET = 4'he;
	localparam logic [4:0] COUNT_RESET = 5'h00;
	localparam logic [4:0] COUNT_FULL = 5'h10;
	localparam int SYNC_STAGES = 3;
	localparam int AMP_COUNT = 2;

	typedef struct packed {
		logic select_n;
		logic frame;
		logic sclk;
		logic data;
	} sdwl_pins_t;

	typedef struct packed {
		logic settling_speed_bit;
		logic power_down_bit;
		logic [11:0] code;
	} sdwl_latch_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_WAIT_RISE,
		ST_DONE
	} sdwl_state_t;
endpackage

// ### rtl/sdwl_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sdwl_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Raw pins and filtered level
	input wire logic [WIDTH-1:0] i_async,
	input wire logic [WIDTH-1:0] i_reset_level,
	output logic [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
	logic [WIDTH-1:0] s1_next, s2_next, s3_next, lvl_next;

	always_comb begin
		s1_next = i_async;
		s2_next = s1_reg;
		s3_next = s2_reg;
		// Change counts once the second and third stages agree
		lvl_next = lvl_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				lvl_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s1_reg <= i_reset_level;
			s2_reg <= i_reset_level;
			s3_reg <= i_reset_level;
			lvl_reg <= i_reset_level;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			lvl_reg <= lvl_next;
		end
	end

	assign o_level = lvl_reg;
endmodule

// ### dv/sdwl_host.sv
// Host serial port model
`timescale 1ns/1ps
module sdwl_host (
	// Clock and pins
	input wire logic i_clock,
	output sdwl_pkg::sdwl_pins_t o_pins
);
	initial o_pins = 4'hf;
	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic send(input logic [15:0] w, input int n,
		input logic s, stall);
		o_pins.select_n = s;
		tick(10);
		o_pins.frame = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_pins.data = w[15-i];
			tick(4);
			o_pins.sclk = 1'b0;
			tick((stall && i == n - 1) ? 16 : 4);
			o_pins.sclk = 1'b1;
		end
		tick(8);
		o_pins.frame = 1'b1;
		o_pins.data = ~o_pins.data;
		tick(10);
		o_pins.select_n = 1'b1;
	endtask
endmodule

// ### dv/sdwl_checker.sv
// Loader port assertions
`timescale 1ns/1ps
module sdwl_checker #(parameter int AMPS = sdwl_pkg::AMP_COUNT) (
	// Watched ports
	input logic i_clock,
	input logic i_rst_n,
	input logic i_select_n,
	input logic i_word_framing_strobe,
	input logic i_sclk,
	input logic [11:0] o_code,
	input logic o_power_down_bit,
	input logic [AMPS-1:0] o_amp_disable,
	input logic o_update
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_amp_follow: assert property (
		o_amp_disable == {AMPS{o_power_down_bit}}) else $error("amp");
	a_change_upd: assert property (
		$changed(o_code) |-> o_update) else $error("code moved");
	a_upd_pulse: assert property (
		o_update |=> !o_update[*8]) else $error("long update");
	a_sel_block: assert property (
		i_select_n[*8] |=> !o_update) else $error("deselected update");
	a_sel_hold: assert property (
		i_select_n[*8] |=> $stable(o_code)) else $error("deselected code");
	a_wait_rise: assert property (
		(!i_sclk && !i_word_framing_strobe)[*8] |=> !o_update)
		else $error("early update");
	a_frame_idle: assert property (
		i_word_framing_strobe[*8] |=> !o_update) else $error("idle update");
	a_reset_zero: assert property (disable iff (1'b0)
		!i_rst_n |=> o_code == 12'h000 && !o_update) else $error("reset");
endmodule
bind sdwl_loader sdwl_checker #(.AMPS(AMPS)) u_chk (.i_clock(i_clock),
	.i_rst_n(i_rst_n), .i_select_n(i_select_n), .i_sclk(i_sclk),
	.i_word_framing_strobe(i_word_framing_strobe), .o_code(o_code),
	.o_power_down_bit(o_power_down_bit), .o_amp_disable(o_amp_disable),
	.o_update(o_update));

// ### dv/serial_dac_word_loader_bench.sv
// Bench for the serial word loader
`timescale 1ns/1ps
module serial_dac_word_loader_bench;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	sdwl_pkg::sdwl_pins_t p;
	wire [15:0] q;
	wire upd;
	localparam int UPDATES = 6;
	int n_upd = 0;
	int errors = 0;
	int num_checks = 0;
	logic [32:0] rows [4] = '{33'h0_9abc_0abc, 33'h0_4fff_8fff,
		33'h1_2000_7000, 33'h0_7123_f123};
	initial forever #50 i_clock = ~i_clock;
	sdwl_host h (.i_clock(i_clock), .o_pins(p));
	sdwl_loader DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_select_n(p.select_n), .i_word_framing_strobe(p.frame),
		.i_sclk(p.sclk), .i_sdata(p.data), .o_code(q[11:0]),
		.o_settling_speed_bit(q[15]), .o_power_down_bit(q[14]),
		.o_amp_disable(q[13:12]), .o_update(upd));
	always @(negedge i_clock) begin
		if (upd === 1'b1) begin
			n_upd++;
		end
	end
	task automatic check(input logic [15:0] e, input logic [15:0] m);
		num_checks++;
		if ((q & m) !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, q & m, e);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		h.tick(8);
		i_rst_n = 1'b1;
		check(16'h0000, 16'hffff);
		foreach (rows[k]) begin
			h.send(rows[k][31:16], 16, 1'b0, rows[k][32]);
			check(rows[k][15:0], 16'hffff);
		end
		h.send(16'h0a5f, 16, 1'b1, 1'b0);
		check(16'hf123, 16'hffff);
		h.send(16'ha5ff, 8, 1'b0, 1'b0);
		check(16'h73a5, 16'hffff);
		i_rst_n = 1'b0;
		h.tick(2);
		i_rst_n = 1'b1;
		check(16'h0000, 16'hffff);
		h.send(rows[3][31:16], 16, 1'b0, 1'b0);
		check(rows[3][15:0], 16'hffff);
		num_checks++;
		if (n_upd !== UPDATES) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, n_upd, UPDATES);
		end
		close_out();
	end
endmodule
